// >>> rtl/rbfc_pkg.sv
// Package of constants and types for the reserved-bit and feature check unit.
package rbfc_pkg;

    // ****************************************************************
    // Widths and generations
    // ****************************************************************
    localparam int unsigned DATA_W    = 32;
    localparam int unsigned GEN_W     = 2;
    localparam int unsigned OPC_W     = 8;
    localparam int unsigned FEAT_W    = 16;

    // Generation codes; the fourth control register exists from GEN_CRF.
    localparam logic [1:0] GEN_OLD    = 2'h0;
    localparam logic [1:0] GEN_CRF    = 2'h1;
    localparam logic [1:0] GEN_MSRCHK = 2'h2;

    // ****************************************************************
    // Reset values and masks
    // ****************************************************************
    localparam logic [31:0] CRF_RESET       = 32'h0000_0000;
    localparam logic [31:0] CRF_DEF_MASK    = 32'h0000_07FF;
    localparam logic [31:0] MSR_RESET       = 32'h0000_0000;
    localparam logic [31:0] MSR_DEF_MASK    = 32'h0000_FFFF;
    localparam logic [31:0] FLAGS_DEF_MASK  = 32'h0020_0FD5;
    localparam logic [15:0] FEATURES_RESET  = 16'h00F1;

    // ****************************************************************
    // Operations presented by the decoder
    // ****************************************************************
    typedef enum logic [2:0] {
        RBFC_OP_NONE   = 3'h0,
        RBFC_OP_CRF_RD = 3'h1,
        RBFC_OP_CRF_WR = 3'h2,
        RBFC_OP_MSR_WR = 3'h3,
        RBFC_OP_FLAG   = 3'h4,
        RBFC_OP_INSN   = 3'h5,
        RBFC_OP_IDENT  = 3'h6
    } rbfc_op_t;

    // Verdict states, Gray coded along the usual path.
    typedef enum logic [1:0] {
        RBFC_ST_IDLE  = 2'h0,
        RBFC_ST_OK    = 2'h1,
        RBFC_ST_FAULT = 2'h3
    } rbfc_st_t;

endpackage

// >>> rtl/rbfc_chk_if.sv
// Interface carrying a write request into the reserved-bit comparator.
`timescale 1ns/1ps
`default_nettype none
interface rbfc_chk_if;
    logic [31:0] old_val;   // Present register contents.
    logic [31:0] new_val;   // Value software wants to write.
    logic [31:0] def_mask;  // Ones mark defined bits.
    logic        enable;    // Check is active.
    logic        bad;       // A reserved bit would change.
    modport src (output old_val, new_val, def_mask, enable, input bad);
    modport chk (input old_val, new_val, def_mask, enable, output bad);
endinterface
`default_nettype wire

// >>> rtl/rbfc_resv_cmp.sv
// Comparator that flags a change of any reserved bit.
`timescale 1ns/1ps
`default_nettype none
module rbfc_resv_cmp (
    rbfc_chk_if.chk c       // Request and verdict.
);
    // A reserved bit differs from its present value while enabled.
    wire logic [31:0] diff;
    assign diff  = (c.old_val ^ c.new_val) & ~c.def_mask;
    assign c.bad = c.enable & (|diff);
endmodule
`default_nettype wire

// >>> rtl/rbfc_top.sv
// Reserved-bit and feature-presence check unit of a processor core.
// How it works
// - No fourth control register: any access raises invalid opcode.
// - Changing its reserved bits by a write raises general protection.
// - Older generations never check model-specific register reserved bits.
// - Testing a flag reserved on this implementation raises an exception.
// - Unsupported instruction raises invalid opcode.
// - Identify instruction returns the implemented feature mask directly.
`timescale 1ns/1ps
`default_nettype none
module rbfc_top
    import rbfc_pkg::*;
#(
    parameter logic [1:0]  GENERATION = GEN_CRF,        // Core generation.
    parameter logic [15:0] FEATURES   = FEATURES_RESET, // Implemented set.
    parameter logic [31:0] CRF_MASK   = CRF_DEF_MASK,   // Defined bits.
    parameter logic [31:0] MSR_MASK   = MSR_DEF_MASK,   // Defined bits.
    parameter logic [31:0] FLAG_MASK  = FLAGS_DEF_MASK  // Defined flags.
) (
    input  wire logic        i_clk,       // Core clock, 200 MHz.
    input  wire logic        i_rst_b,     // Asynchronous reset, active low.
    input  wire logic        i_valid,     // Operation presented this cycle.
    input  wire rbfc_op_t    i_op,        // Operation kind.
    input  wire logic [31:0] i_wdata,     // Write value or flag select mask.
    input  wire logic [3:0]  i_feat_sel,  // Feature needed by an instruction.
    output logic             o_done,      // Verdict pulse.
    output logic             o_ud_fault,  // Invalid opcode fault pulse.
    output logic             o_gp_fault,  // General protection fault pulse.
    output logic [31:0]      o_rdata,     // Read or identify result.
    output logic [31:0]      o_control_reg_four, // Fourth control register.
    output logic [31:0]      o_msr        // Model-specific register.
);

    // ****************************************************************
    // Decode
    // ****************************************************************
    wire logic has_crf;
    wire logic msr_chk_on;
    wire logic is_crf;
    wire logic crf_wr;
    wire logic msr_wr;
    wire logic ud_crf;
    wire logic ud_insn;
    wire logic flag_bad;
    wire logic gp_crf;
    wire logic gp_msr;
    wire logic any_ud;
    wire logic any_gp;
    wire logic [31:0] next_rdata;

    rbfc_chk_if crf_if ();
    rbfc_chk_if msr_if ();

    logic [31:0] control_reg_four;
    logic [31:0] msr;
    rbfc_st_t    state;

    assign has_crf    = (GENERATION != GEN_OLD);
    assign msr_chk_on = (GENERATION == GEN_MSRCHK);
    assign is_crf     = i_valid &
                        ((i_op == RBFC_OP_CRF_RD) | (i_op == RBFC_OP_CRF_WR));
    assign crf_wr     = i_valid & (i_op == RBFC_OP_CRF_WR);
    assign msr_wr     = i_valid & (i_op == RBFC_OP_MSR_WR);
    assign ud_crf     = is_crf & ~has_crf;
    assign ud_insn    = i_valid & (i_op == RBFC_OP_INSN) &
                        ~FEATURES[i_feat_sel];
    assign flag_bad   = i_valid & (i_op == RBFC_OP_FLAG) &
                        (|(i_wdata & ~FLAG_MASK));
    assign any_ud     = ud_crf | ud_insn;
    assign any_gp     = gp_crf | gp_msr | flag_bad;

    // Comparator inputs; the model-specific check runs on later generations.
    assign crf_if.old_val  = control_reg_four;
    assign crf_if.new_val  = i_wdata;
    assign crf_if.def_mask = CRF_MASK;
    assign crf_if.enable   = crf_wr & has_crf;
    assign gp_crf          = crf_if.bad;
    assign msr_if.old_val  = msr;
    assign msr_if.new_val  = i_wdata;
    assign msr_if.def_mask = MSR_MASK;
    assign msr_if.enable   = msr_wr & msr_chk_on;
    assign gp_msr          = msr_if.bad;

    rbfc_resv_cmp u_cmp_crf (.c(crf_if));
    rbfc_resv_cmp u_cmp_msr (.c(msr_if));

    // Read data: identify returns features, a control read its contents.
    assign next_rdata =
        (i_valid & (i_op == RBFC_OP_IDENT)) ? {16'h0000, FEATURES} :
        (is_crf & has_crf & (i_op == RBFC_OP_CRF_RD)) ? control_reg_four :
        32'h0000_0000;

    // ****************************************************************
    // Registers
    // ****************************************************************

    // Control registers update only on a write that does not fault.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            control_reg_four <= CRF_RESET;
            msr <= MSR_RESET;
        end else begin
            if (crf_wr & has_crf & ~gp_crf) begin
                control_reg_four <= i_wdata;
            end
            if (msr_wr & ~gp_msr) begin
                msr <= i_wdata;
            end
        end
    end

    // Verdict state and registered outputs.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state      <= RBFC_ST_IDLE;
            o_done     <= 1'b0;
            o_ud_fault <= 1'b0;
            o_gp_fault <= 1'b0;
            o_rdata    <= 32'h0000_0000;
        end else begin
            o_done     <= i_valid;
            o_ud_fault <= any_ud;
            o_gp_fault <= any_gp & ~any_ud;
            o_rdata    <= next_rdata;
            case (state)
                RBFC_ST_IDLE, RBFC_ST_OK, RBFC_ST_FAULT: begin
                    if (!i_valid) begin
                        state <= RBFC_ST_IDLE;
                    end else if (any_ud | any_gp) begin
                        state <= RBFC_ST_FAULT;
                    end else begin
                        state <= RBFC_ST_OK;
                    end
                end
                default: begin
                    state <= RBFC_ST_IDLE;
                end
            endcase
        end
    end

    // Outputs show the registers directly.
    assign o_control_reg_four = control_reg_four;
    assign o_msr              = msr;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    // A missing control register faults and stays untouched.
    a_ud_old_crf: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        is_crf && !has_crf |=> o_ud_fault && $stable(control_reg_four))
        else $error("Old generation control access did not fault.");

    // A changed reserved control bit faults.
    a_gp_resv_change: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        crf_wr && has_crf &&
        |((control_reg_four ^ i_wdata) & ~CRF_MASK) |=> o_gp_fault)
        else $error("Reserved control bit change did not fault.");

    // Older generations store model-specific writes unchecked.
    a_msr_unchecked: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        msr_wr && !msr_chk_on |=> !o_gp_fault && o_msr == $past(i_wdata))
        else $error("Model-specific write checked on old generation.");

    // Later generations refuse a reserved model-specific change.
    a_msr_checked: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        msr_wr && msr_chk_on && |((msr ^ i_wdata) & ~MSR_MASK) |=>
        o_gp_fault && $stable(o_msr))
        else $error("Reserved model-specific change did not fault.");

    // A reserved flag test faults unless invalid opcode wins.
    a_flag_resv: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        flag_bad && !any_ud |=> o_gp_fault)
        else $error("Reserved flag test did not fault.");

    // Instructions fault exactly when their feature is absent.
    a_ud_insn: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        i_valid && i_op == RBFC_OP_INSN |=>
        o_ud_fault == !FEATURES[$past(i_feat_sel)])
        else $error("Unsupported instruction verdict wrong.");

    // Identify returns the implemented feature set with a verdict.
    a_ident_data: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        i_valid && i_op == RBFC_OP_IDENT |=>
        o_rdata == {16'h0000, FEATURES} && o_done)
        else $error("Identify returned wrong features.");

    // A faulting control write leaves the register as it was.
    a_fault_keeps: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        gp_crf |=> o_control_reg_four == $past(o_control_reg_four))
        else $error("Faulting control write changed the register.");

    // A clean control write is taken whole and does not fault.
    a_good_write: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        crf_wr && has_crf && !gp_crf |=>
        o_control_reg_four == $past(i_wdata) && !o_gp_fault)
        else $error("Clean control write not taken.");

    // The verdict state agrees with the fault pulses.
    a_state_verdict: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        (state == RBFC_ST_FAULT) == (o_ud_fault || o_gp_fault))
        else $error("Verdict state disagrees with fault pulses.");

    // Invalid opcode takes precedence, so the two faults never coincide.
    a_one_fault: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        !(o_ud_fault && o_gp_fault))
        else $error("Both fault pulses raised together.");

    // Main scenarios.
    c_gp_seen: cover property (@(posedge i_clk) o_gp_fault);
    c_ud_seen: cover property (@(posedge i_clk) o_ud_fault);
    c_good_crf: cover property (@(posedge i_clk)
        crf_wr && has_crf && !gp_crf ##1 o_done);
    c_msr_gp: cover property (@(posedge i_clk)
        msr_wr && msr_chk_on ##1 o_gp_fault);

endmodule
`default_nettype wire

// >>> bench/rbfc_top_bench.sv
// Self-checking bench for the reserved-bit and feature check unit.
`timescale 1ns/1ps
`default_nettype none
module rbfc_top_bench
    import rbfc_pkg::*;
;
    // ************************************************************
    // Stimulus, observed outputs and counters
    // ************************************************************
    logic              i_clk      = 1'b0;
    logic              i_rst_b    = 1'b0;
    logic              i_valid    = 1'b0;
    rbfc_op_t          i_op       = RBFC_OP_NONE;
    logic [31:0]       i_wdata    = 32'h0;
    logic [3:0]        i_feat_sel = 4'h0;
    wire logic [2:0]   done;
    wire logic [2:0]   ud;
    wire logic [2:0]   gp;
    wire logic [2:0][31:0] rdata;
    wire logic [2:0][31:0] crf;
    wire logic [2:0][31:0] msr;
    int                err_total  = 0;
    int                num_checks = 0;

    // Core clock at 200 MHz.
    always #2.5 i_clk = ~i_clk;

    // Unit 0 has the control register, unit 1 lacks it, unit 2 also
    // checks model-specific writes.
    for (genvar g = 0; g < 3; g++) begin : gen_core
        rbfc_top #(
            .GENERATION (g == 0 ? GEN_CRF : (g == 1 ? GEN_OLD : GEN_MSRCHK))
        ) rbfc_top_i (
            .i_clk      (i_clk),
            .i_rst_b    (i_rst_b),
            .i_valid    (i_valid),
            .i_op       (i_op),
            .i_wdata    (i_wdata),
            .i_feat_sel (i_feat_sel),
            .o_done     (done[g]),
            .o_ud_fault (ud[g]),
            .o_gp_fault (gp[g]),
            .o_rdata    (rdata[g]),
            .o_control_reg_four (crf[g]),
            .o_msr      (msr[g])
        );
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    // Compares one value and counts the outcome.
    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Presents one operation; results are settled when it returns.
    task automatic do_op(input rbfc_op_t op, input logic [31:0] wd,
                         input logic [3:0] fs);
        @(posedge i_clk);
        i_valid    <= 1'b1;
        i_op       <= op;
        i_wdata    <= wd;
        i_feat_sel <= fs;
        @(posedge i_clk);
        i_valid    <= 1'b0;
        #1;
        chk("done", {29'h0, done}, 32'h7);
    endtask

    // Prints the verdict and ends the run.
    task automatic test_done;
        if (err_total == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    // Control register writes, a reserved change and a read back.
    task automatic t_crf;
        // Reserved bits are reloaded as they read after reset.
        do_op(RBFC_OP_CRF_WR, 32'h0000_0155, 4'h0);
        chk("gp_def", {29'h0, gp}, 32'h0);
        chk("ud_wr", {29'h0, ud}, 32'h2);
        chk("crf_new", crf[0], 32'h0000_0155);
        chk("crf_new2", crf[2], 32'h0000_0155);
        chk("crf_old", crf[1], CRF_RESET);
        do_op(RBFC_OP_CRF_WR, 32'h0000_0955, 4'h0);
        chk("gp_resv", {29'h0, gp}, 32'h5);
        chk("crf_kept", crf[0], 32'h0000_0155);
        chk("crf_kept2", crf[2], 32'h0000_0155);
        do_op(RBFC_OP_CRF_RD, 32'h0, 4'h0);
        chk("ud_rd", {29'h0, ud}, 32'h2);
        chk("crf_rd", rdata[0], 32'h0000_0155);
        chk("rd_old", rdata[1], 32'h0);
        chk("crf_test", rdata[2] & CRF_DEF_MASK, 32'h0000_0155);
    endtask

    // Model-specific writes: stored unchecked, refused on the last unit.
    task automatic t_msr;
        do_op(RBFC_OP_MSR_WR, 32'h0001_0000, 4'h0);
        chk("gp_msr", {29'h0, gp}, 32'h4);
        chk("ud_msr", {29'h0, ud}, 32'h0);
        chk("msr_new", msr[0], 32'h0001_0000);
        chk("msr_old", msr[1], 32'h0001_0000);
        chk("msr_kept", msr[2], MSR_RESET);
        chk("msr_def", msr[0] & MSR_DEF_MASK, 32'h0);
    endtask

    // A reserved flag test faults, a defined one does not.
    task automatic t_flag;
        do_op(RBFC_OP_FLAG, 32'h0000_0002, 4'h0);
        chk("gp_flag", {29'h0, gp}, 32'h7);
        do_op(RBFC_OP_FLAG, 32'h0000_0001, 4'h0);
        chk("gp_flag_ok", {29'h0, gp}, 32'h0);
    endtask

    // Every feature index; absent features give invalid opcode.
    task automatic t_insn;
        for (int i = 0; i < 16; i++) begin
            do_op(RBFC_OP_INSN, 32'h0, 4'(i));
            chk("ud_insn", 32'(ud), 32'({3{~FEATURES_RESET[i]}}));
        end
    endtask

    // Identify returns the implemented feature set.
    task automatic t_ident;
        do_op(RBFC_OP_IDENT, 32'h0, 4'h0);
        chk("ident", rdata[0], {16'h0, FEATURES_RESET});
        chk("ident_old", rdata[1], {16'h0, FEATURES_RESET});
        chk("ident_new", rdata[2], {16'h0, FEATURES_RESET});
    endtask

    // ************************************************************
    // Main sequence and watchdog
    // ************************************************************
    // Reset for two cycles, then run every scenario.
    initial begin
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'b1;
        chk("crf_rst", crf[0], CRF_RESET);
        t_crf;
        t_msr;
        t_flag;
        t_insn;
        t_ident;
        test_done;
    end

    // Cuts a hang short well after the roughly 50 cycles needed.
    initial begin
        repeat (1000) @(posedge i_clk);
        err_total++;
        test_done;
    end
endmodule
`default_nettype wire
